// ===== bench/prmc_bench.sv
`timescale 1ns/1ps
// ==================================================
// Self-checking bench for the power reduction mode controller
module prmc_bench;
	import prmc_pkg::*;
	logic sys_clk, rstn, idle_instr, powerdown_instr, irq_req, bus_ready_seen;
	logic go, pfail, nmi_n, bus_busy;
	logic [3:0] busy_len, wake_len;
	logic [2:0] wake_sel;
	logic [7:0] ext_wake_irq_pin, wake_irq_flag;
	logic mode_ack, cpu_clk_en, periph_clk_en, osc_pll_en, weak_pulldown_en;
	logic resume_pulse, wake_isr_req, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb, mon;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	int mismatches, total_checks, n;
	bit got;

	// ==================================================
	// Instances
	prmc_top i_prmc_top (.sys_clk, .rstn, .idle_instr, .powerdown_instr, .irq_req, .nmi_n,
		.bus_busy, .bus_ready_seen, .ext_wake_irq_pin, .mode_ack, .cpu_clk_en, .periph_clk_en,
		.osc_pll_en, .weak_pulldown_en, .resume_pulse, .wake_isr_req, .wake_irq_flag, .irq,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	prmc_far_model i_prmc_far_model (.sys_clk, .rstn, .go, .busy_len, .wake_len, .wake_sel,
		.pfail, .bus_busy, .nmi_n, .ext_wake_irq_pin);
	// Signals the wait task can watch by index
	assign mon = {resume_pulse, cpu_clk_en, mode_ack, osc_pll_en};

	// ==================================================
	// Helpers
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Wait up to 20 cycles for a watched signal; the answer has no fixed latency
	task wait_hi(input int b, output bit g);
		g = 0;
		n = 0;
		while (!g && n < 20)
		begin
			@(posedge sys_clk);
			#1;
			n++;
			g = (mon[b] === 1'b1);
		end
	endtask
	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Each channel is released at the edge that takes it
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Issue a mode instruction with a bus cycle of bl cycles pending, then wait for ack
	task enter(input bit pd, input logic [3:0] bl);
		@(posedge sys_clk);
		idle_instr <= !pd;
		powerdown_instr <= pd;
		go <= 1'b1;
		busy_len <= bl;
		wake_len <= 4'h0;
		@(posedge sys_clk);
		idle_instr <= 1'b0;
		powerdown_instr <= 1'b0;
		go <= 1'b0;
		wait_hi(1, got);
		if (got)
		begin
			chk(n > bl, 1);
			chk(cpu_clk_en, 1);
		end
	endtask
	task reset;
		rstn <= 1'b0;
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
	endtask

	// ==================================================
	// Scenarios
	task t_idle;
		axi_wr(PRMC_IRQ_MASK_OFS, 32'h1 << PRMC_IRQ_IDLE_BIT, rs);
		enter(0, 4'h3);
		chk(got, 1);
		@(posedge sys_clk);
		#1;
		chk({cpu_clk_en, periph_clk_en, osc_pll_en}, 3'h3);
		@(posedge sys_clk);
		irq_req <= 1'b1;
		wait_hi(2, got);
		chk(got, 1);
		irq_req <= 1'b0;
		axi_rd(PRMC_IRQ_STAT_OFS, rd, rs);
		chk(rd[PRMC_IRQ_IDLE_BIT], 1);
		chk(irq, 1);
		axi_wr(PRMC_IRQ_STAT_OFS, 32'hF, rs);
		repeat (3) @(posedge sys_clk);
		chk(irq, 0);
		axi_rd(8'h20, rd, rs);
		chk({rs, rd}, {PRMC_RESP_SLVERR, 32'h0});
		axi_wr(8'h24, 32'h1, rs);
		chk(rs, PRMC_RESP_SLVERR);
	endtask
	task t_refuse;
		axi_wr(PRMC_CFG_OFS, 32'h1 << PRMC_CFG_RDYEN_BIT, rs);
		bus_ready_seen <= 1'b0;
		enter(0, 4'h0);
		chk(got, 0);
		axi_rd(PRMC_IRQ_STAT_OFS, rd, rs);
		chk(rd[PRMC_IRQ_REFUSE_BIT], 1);
		axi_wr(PRMC_IRQ_STAT_OFS, 32'hF, rs);
		axi_wr(PRMC_CFG_OFS, 32'h0, rs);
		bus_ready_seen <= 1'b1;
	endtask
	task t_protected;
		enter(1, 4'h0);
		chk({got, cpu_clk_en}, 2'h1);
		pfail <= 1'b1;
		enter(1, 4'h2);
		chk(got, 1);
		@(posedge sys_clk);
		#1;
		chk({cpu_clk_en, periph_clk_en}, 2'h0);
		// Neither a wake pulse nor an interrupt may end this variant
		go <= 1'b1;
		wake_len <= 4'h6;
		irq_req <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (15) @(posedge sys_clk);
		chk(cpu_clk_en, 0);
		irq_req <= 1'b0;
		pfail <= 1'b0;
		reset;
		#1;
		chk(cpu_clk_en, 1);
	endtask
	task t_wake(input logic [2:0] pin, input bit en);
		axi_wr(PRMC_CFG_OFS, 32'h1 << PRMC_CFG_WAKECFG_BIT, rs);
		axi_wr(PRMC_WAKE_EN_OFS, 32'(en) << pin, rs);
		wake_sel <= pin;
		enter(1, 4'h0);
		chk(got, 1);
		@(posedge sys_clk);
		#1;
		chk({cpu_clk_en, periph_clk_en, osc_pll_en}, 3'h0);
		// A 30 ns pulse is too short to wake
		@(posedge sys_clk);
		go <= 1'b1;
		wake_len <= 4'h3;
		irq_req <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (10) @(posedge sys_clk);
		irq_req <= 1'b0;
		chk(osc_pll_en, 0);
		go <= 1'b1;
		wake_len <= 4'h4;
		@(posedge sys_clk);
		go <= 1'b0;
		wait_hi(0, got);
		chk({got, weak_pulldown_en}, 2'h3);
		wait_hi(3, got);
		chk({got, wake_isr_req}, {1'b1, en});
		wait_hi(2, got);
		chk(got, 1);
		chk(wake_irq_flag[pin], 1);
		axi_rd(PRMC_IRQ_STAT_OFS, rd, rs);
		chk({rd[PRMC_IRQ_PD_BIT], rd[PRMC_IRQ_WAKE_BIT]}, 2'h3);
		axi_wr(PRMC_IRQ_STAT_OFS, 32'hF, rs);
		axi_rd(PRMC_WAKE_FLAG_OFS, rd, rs);
		if (!en)
			chk(rd[pin], 1);
		axi_wr(PRMC_WAKE_FLAG_OFS, 32'h1 << pin, rs);
		axi_rd(PRMC_WAKE_FLAG_OFS, rd, rs);
		chk(rd[pin], 0);
	endtask

	// ==================================================
	// Clock, main sequence and watchdog
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial
	begin
		{rstn, idle_instr, powerdown_instr, irq_req, go, pfail} = '0;
		{busy_len, wake_len, wake_sel, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		bus_ready_seen = 1'b1;
		mismatches = 0;
		total_checks = 0;
		reset;
		#1;
		chk({cpu_clk_en, periph_clk_en, osc_pll_en, mode_ack}, 4'hE);
		axi_rd(PRMC_CFG_OFS, rd, rs);
		chk({rs, rd}, {PRMC_RESP_OKAY, 29'h0, PRMC_CFG_RESET});
		t_idle;
		t_refuse;
		t_protected;
		t_wake(3'h5, 1'b1);
		t_wake(3'h2, 1'b0);
		summarize;
	end
	// Whole run is a few hundred cycles; this limit only cuts a hang
	initial
	begin
		#400000;
		mismatches++;
		summarize;
	end
endmodule

// ===== bench/prmc_far_model.sv
`timescale 1ns/1ps
// ==================================================
// Far side: bus controller, power-fail logic, wake pins
module prmc_far_model
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Commands from the bench, go loads both counts
	input wire logic go,
	input wire logic [3:0] busy_len,
	input wire logic [3:0] wake_len,
	input wire logic [2:0] wake_sel,
	input wire logic pfail,
	// Pins toward the block
	output logic bus_busy,
	output logic nmi_n,
	output logic [7:0] ext_wake_irq_pin
);
	logic [3:0] busy_cnt_reg;
	logic [3:0] wake_cnt_reg;
	// Pending bus cycle and wake pulse widths, counted in clock cycles
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			busy_cnt_reg <= 4'h0;
			wake_cnt_reg <= 4'h0;
		end
		else if (go)
		begin
			busy_cnt_reg <= busy_len;
			wake_cnt_reg <= wake_len;
		end
		else
		begin
			busy_cnt_reg <= busy_cnt_reg - 4'((busy_cnt_reg != 4'h0));
			wake_cnt_reg <= wake_cnt_reg - 4'((wake_cnt_reg != 4'h0));
		end
	end
	// Power-fail logic pulls the NMI pin low; released pins fall to the pulldown
	assign nmi_n = ~pfail;
	assign bus_busy = (busy_cnt_reg != 4'h0);
	assign ext_wake_irq_pin = (wake_cnt_reg != 4'h0) ? (8'h01 << wake_sel) : 8'h00;
endmodule

// ===== hdl/prmc_pkg.sv
package prmc_pkg;
	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] PRMC_CFG_OFS = 8'h00;
	localparam logic [7:0] PRMC_STAT_OFS = 8'h04;
	localparam logic [7:0] PRMC_IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] PRMC_IRQ_MASK_OFS = 8'h0C;
	localparam logic [7:0] PRMC_WAKE_FLAG_OFS = 8'h10;
	localparam logic [7:0] PRMC_WAKE_EN_OFS = 8'h14;
	// Config register fields
	localparam int PRMC_CFG_WAKECFG_BIT = 0;
	localparam int PRMC_CFG_RDYEN_BIT = 1;
	localparam int PRMC_CFG_RDYPOL_BIT = 2;
	localparam logic [2:0] PRMC_CFG_RESET = 3'h0;
	// Interrupt status fields
	localparam int PRMC_IRQ_IDLE_BIT = 0;
	localparam int PRMC_IRQ_PD_BIT = 1;
	localparam int PRMC_IRQ_WAKE_BIT = 2;
	localparam int PRMC_IRQ_REFUSE_BIT = 3;
	localparam int PRMC_IRQ_W = 4;
	// Wake pins and least wake pulse
	localparam int PRMC_WAKE_PINS = 8;
	localparam int PRMC_CLK_PERIOD_NS = 10;
	localparam int PRMC_WAKE_MIN_NS = 40;
	localparam int PRMC_WAKE_MIN_CYC = (PRMC_WAKE_MIN_NS + PRMC_CLK_PERIOD_NS - 1)
		/ PRMC_CLK_PERIOD_NS;
	localparam logic [1:0] PRMC_RESP_OKAY = 2'h0;
	localparam logic [1:0] PRMC_RESP_SLVERR = 2'h2;
	// Mode state, Gray along run -> drain -> idle and power-down -> wake, except drain -> power-down (two bits)
	typedef enum logic [2:0] {
		PRMC_RUN = 3'h0,
		PRMC_DRAIN = 3'h1,
		PRMC_IDLE = 3'h3,
		PRMC_PDOWN = 3'h2,
		PRMC_WAKE = 3'h6
	} prmc_state_t;
endpackage

// ===== hdl/prmc_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Idle halts the processor; peripheral clocks keep running.
// - Any reset or interrupt request ends idle mode.
// - Power-down stops both processor and peripherals.
// - Config picks power-down exit: hardware reset only, or external wake pin.
// - Config bit zero clear selects protected power-down.
// - Protected entry only if NMI still low; else execution continues.
// - Config bit set: freeze clocks, stop oscillator and PLL.
// - Qualified wake restarts oscillator and PLL and turns on weak pulldown.
// - Enabled waking interrupt is serviced, then resume after instruction.
// - Disabled waking interrupt resumes directly; its flag stays until cleared.
// - Pending external bus actions finish before any low-power mode.
module prmc_top
	import prmc_pkg::*;
#(
	parameter int NPINS = prmc_pkg::PRMC_WAKE_PINS
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Core requests
	input wire logic idle_instr,
	input wire logic powerdown_instr,
	input wire logic irq_req,
	input wire logic nmi_n,
	// External bus controller
	input wire logic bus_busy,
	input wire logic bus_ready_seen,
	// Wake pins
	input wire logic [NPINS-1:0] ext_wake_irq_pin,
	// Clock and core control
	output logic mode_ack,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic osc_pll_en,
	output logic weak_pulldown_en,
	output logic resume_pulse,
	output logic wake_isr_req,
	output logic [NPINS-1:0] wake_irq_flag,
	output logic irq,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import prmc_pkg::*;

	// ==========================================================
	// Declarations
	prmc_state_t state_reg;
	logic pd_kind_reg; // Remembers which variant was entered
	logic [2:0] system_config_reg;
	logic [PRMC_IRQ_W-1:0] irq_stat_reg;
	logic [PRMC_IRQ_W-1:0] irq_mask_reg;
	logic [NPINS-1:0] wake_en_reg;
	logic [NPINS-1:0] qual;
	logic [PRMC_IRQ_W-1:0] ev;
	logic powerdown_wake_cfg;
	logic ready_ok;
	logic any_wake;
	logic req_pd_reg;
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_fire;
	logic [NPINS-1:0] flag_clr;
	logic [PRMC_IRQ_W-1:0] stat_clr;

	assign powerdown_wake_cfg = system_config_reg[PRMC_CFG_WAKECFG_BIT];
	// Ready handshake must have been seen unless checking is disabled
	assign ready_ok = !system_config_reg[PRMC_CFG_RDYEN_BIT] || bus_ready_seen;

	// ==========================================================
	// Wake pin qualification, one filter per pin
	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi++)
		begin : g_wake
			prmc_wake_filter u_filt (
				.sys_clk(sys_clk),
				.rstn(rstn),
				.pin(ext_wake_irq_pin[gi]),
				.qualified(qual[gi])
			);
		end
	endgenerate
	assign any_wake = |qual;

	// ==========================================================
	// Mode request latch: single-cycle core pulse held while bus drains
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			req_pd_reg <= 1'b0;
		else if (state_reg == PRMC_RUN && (idle_instr || powerdown_instr))
			req_pd_reg <= powerdown_instr;
	end

	// ==========================================================
	// Mode state machine
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= PRMC_RUN; // Any reset ends either mode
			pd_kind_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				PRMC_RUN:
					if (idle_instr || powerdown_instr)
						state_reg <= PRMC_DRAIN;
				PRMC_DRAIN:
					if (!bus_busy)
					begin
						if (!ready_ok)
							state_reg <= PRMC_RUN;
						else if (!req_pd_reg)
							state_reg <= PRMC_IDLE;
						else if (!powerdown_wake_cfg && nmi_n)
							state_reg <= PRMC_RUN;
						else
						begin
							state_reg <= PRMC_PDOWN;
							pd_kind_reg <= powerdown_wake_cfg;
						end
					end
				PRMC_IDLE:
					if (irq_req)
						state_reg <= PRMC_RUN;
				PRMC_PDOWN:
					if (pd_kind_reg && any_wake) // Protected: only reset exits
						state_reg <= PRMC_WAKE;
				PRMC_WAKE:
					state_reg <= PRMC_RUN;
				default:
					state_reg <= PRMC_RUN;
			endcase
		end
	end

	// ==========================================================
	// Clock controls; ack goes out one cycle before clocks drop
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mode_ack <= 1'b0;
			cpu_clk_en <= 1'b1;
			periph_clk_en <= 1'b1;
			osc_pll_en <= 1'b1;
			weak_pulldown_en <= 1'b0;
		end
		else
		begin
			mode_ack <= (state_reg == PRMC_DRAIN) && !bus_busy && ready_ok
				&& (!req_pd_reg || powerdown_wake_cfg || !nmi_n);
			cpu_clk_en <= !(state_reg == PRMC_IDLE || state_reg == PRMC_PDOWN);
			periph_clk_en <= (state_reg != PRMC_PDOWN);
			osc_pll_en <= !(state_reg == PRMC_PDOWN && pd_kind_reg && !any_wake);
			if (state_reg == PRMC_PDOWN && pd_kind_reg && any_wake)
				weak_pulldown_en <= 1'b1;
			else if (state_reg == PRMC_RUN)
				weak_pulldown_en <= 1'b0;
		end
	end

	// ==========================================================
	// Wake outcome: service routine if enabled, else plain resume
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			resume_pulse <= 1'b0;
			wake_isr_req <= 1'b0;
		end
		else
		begin
			resume_pulse <= (state_reg == PRMC_WAKE)
				|| (state_reg == PRMC_IDLE && irq_req);
			wake_isr_req <= (state_reg == PRMC_WAKE) && |(wake_irq_flag & wake_en_reg);
		end
	end

	// Request flags: set by qualified wake, cleared by writing one; set wins
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			wake_irq_flag <= '0;
		else
			wake_irq_flag <= (wake_irq_flag & ~flag_clr) | qual;
	end

	// ==========================================================
	// Interrupt status: sticky, write one to clear, set wins
	assign ev[PRMC_IRQ_IDLE_BIT] = (state_reg == PRMC_DRAIN) && !bus_busy && ready_ok
		&& !req_pd_reg;
	// First power-down cycle only: peripheral clock still reflects the drain state
	assign ev[PRMC_IRQ_PD_BIT] = (state_reg == PRMC_PDOWN) && periph_clk_en;
	assign ev[PRMC_IRQ_WAKE_BIT] = (state_reg == PRMC_WAKE);
	assign ev[PRMC_IRQ_REFUSE_BIT] = (state_reg == PRMC_DRAIN) && !bus_busy && !ready_ok;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			irq_stat_reg <= '0;
			irq <= 1'b0;
		end
		else
		begin
			irq_stat_reg <= (irq_stat_reg & ~stat_clr) | ev;
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// ==========================================================
	// AXI4-Lite write path: address and data taken in either order
	assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	assign flag_clr = (wr_fire && aw_addr_reg == PRMC_WAKE_FLAG_OFS && w_strb_reg[0])
		? w_data_reg[NPINS-1:0] : '0;
	assign stat_clr = (wr_fire && aw_addr_reg == PRMC_IRQ_STAT_OFS && w_strb_reg[0])
		? w_data_reg[PRMC_IRQ_W-1:0] : '0;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= PRMC_RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr_reg)
					PRMC_CFG_OFS, PRMC_IRQ_STAT_OFS, PRMC_IRQ_MASK_OFS,
					PRMC_WAKE_FLAG_OFS, PRMC_WAKE_EN_OFS, PRMC_STAT_OFS:
						s_axi_bresp <= PRMC_RESP_OKAY;
					default:
						s_axi_bresp <= PRMC_RESP_SLVERR;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Writable control registers
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			system_config_reg <= PRMC_CFG_RESET;
			irq_mask_reg <= '0;
			wake_en_reg <= '0;
		end
		else if (wr_fire && w_strb_reg[0])
		begin
			case (aw_addr_reg)
				PRMC_CFG_OFS: system_config_reg <= w_data_reg[2:0];
				PRMC_IRQ_MASK_OFS: irq_mask_reg <= w_data_reg[PRMC_IRQ_W-1:0];
				PRMC_WAKE_EN_OFS: wake_en_reg <= w_data_reg[NPINS-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// AXI4-Lite read path
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= PRMC_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= PRMC_RESP_OKAY;
				case (s_axi_araddr)
					PRMC_CFG_OFS: s_axi_rdata <= 32'(system_config_reg);
					PRMC_STAT_OFS: s_axi_rdata <= 32'({pd_kind_reg, state_reg});
					PRMC_IRQ_STAT_OFS: s_axi_rdata <= 32'(irq_stat_reg);
					PRMC_IRQ_MASK_OFS: s_axi_rdata <= 32'(irq_mask_reg);
					PRMC_WAKE_FLAG_OFS: s_axi_rdata <= 32'(wake_irq_flag);
					PRMC_WAKE_EN_OFS: s_axi_rdata <= 32'(wake_en_reg);
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= PRMC_RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Assertions
	a_idle_cpu_off: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_reg == PRMC_IDLE && $past(state_reg) == PRMC_IDLE |-> !cpu_clk_en && periph_clk_en)
		else $error("idle must stop cpu clock only");
	a_idle_irq_exit: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_reg == PRMC_IDLE && irq_req |=> state_reg == PRMC_RUN)
		else $error("interrupt did not end idle");
	a_pd_all_off: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_reg == PRMC_PDOWN ##1 state_reg == PRMC_PDOWN |-> !cpu_clk_en && !periph_clk_en)
		else $error("power-down left a clock running");
	a_prot_no_wake: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_reg == PRMC_PDOWN && !pd_kind_reg |=> state_reg == PRMC_PDOWN)
		else $error("protected power-down left without reset");
	a_nmi_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_reg == PRMC_DRAIN && !bus_busy && ready_ok && req_pd_reg && !powerdown_wake_cfg
		&& nmi_n |=> state_reg == PRMC_RUN)
		else $error("protected entry without nmi low");
	a_osc_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_reg == PRMC_PDOWN && pd_kind_reg && !any_wake |=> !osc_pll_en)
		else $error("oscillator not stopped");
	a_wake_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_reg == PRMC_PDOWN && pd_kind_reg && any_wake |=> osc_pll_en && weak_pulldown_en
		##1 state_reg == PRMC_RUN)
		else $error("wake did not restart oscillator");
	a_flag_kept: assert property (@(posedge sys_clk) disable iff (!rstn)
		wake_irq_flag[0] && !flag_clr[0] |=> wake_irq_flag[0])
		else $error("wake flag lost without clear");
	a_bus_drain: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_reg == PRMC_DRAIN && bus_busy |=> state_reg == PRMC_DRAIN)
		else $error("entered low power with bus busy");
	a_ready_refuse: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_reg == PRMC_DRAIN && !bus_busy && !ready_ok |=> state_reg == PRMC_RUN && !mode_ack)
		else $error("entry not refused");
	a_ack_first: assert property (@(posedge sys_clk) disable iff (!rstn)
		$fell(cpu_clk_en) |-> $past(mode_ack))
		else $error("clocks halted before ack");
endmodule

// ===== hdl/prmc_wake_filter.sv
`timescale 1ns/1ps
// Qualifies one wake pin: pulse must stand for the least wake width
module prmc_wake_filter
	import prmc_pkg::*;
#(
	parameter int MIN_CYC = prmc_pkg::PRMC_WAKE_MIN_CYC
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Pin and result
	input wire logic pin,
	output logic qualified
);
	logic [7:0] cnt_reg;

	// Count consecutive high cycles; shorter glitches never qualify
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			cnt_reg <= 8'h00;
		else if (!pin)
			cnt_reg <= 8'h00;
		else if (cnt_reg < 8'(MIN_CYC))
			cnt_reg <= cnt_reg + 8'h01;
	end

	assign qualified = (cnt_reg >= 8'(MIN_CYC));
endmodule
